/* File: rtl/dsprac_top.sv */
// Purpose: replicate, accumulator-shift and packed-halfword left shift execution
// Assumes: pipeline supplies the instruction word and the source register value
// Notes:   accumulator ops take two cycles, register ops one
//
// Behaviour
// - halfword replicate: low half into both halves
// - decode halfword replicate from register
// - byte replicate: low byte into four lanes
// - decode byte replicate from register
// - decode immediate accumulator shift
// - shift joined 64-bit pair, write both words
// - signed amount: positive right, negative left
// - logical shifts, zero fill both directions
// - selector 0..3 picks one of four pairs
// - variable shift amount from source bits 5..0
// - decode variable accumulator shift
// - only reserved and disabled exceptions
// - per-half shift, saturate, set overflow flag
`timescale 1ns/10ps
`default_nettype none
`include "dsprac_regs.svh"
module dsprac_top (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // issue
  input  wire logic                  issueValid,
  input  wire dsprac_pkg::dsprac_word_t issueInstr,
  input  wire dsprac_pkg::dsprac_word_t issueRsValue,
  input  wire logic                  dspEnable,
  output logic                       issueReady,
  // result
  output logic                       resValid,
  output logic                       gprWrEn,
  output logic [4:0]                 gprDest,
  output dsprac_pkg::dsprac_word_t   gprData,
  output logic                       excReserved,
  output logic                       excDspOff,
  output logic                       ouflagSet,
  output logic                       accDone,
  // accumulator load and observation
  input  wire logic                  extWrEn,
  input  wire dsprac_pkg::dsprac_sel_t extWrSel,
  input  wire dsprac_pkg::dsprac_word_t extWrHi,
  input  wire dsprac_pkg::dsprac_word_t extWrLo,
  input  wire dsprac_pkg::dsprac_sel_t peekSel,
  output dsprac_pkg::dsprac_word_t   peekHi,
  output dsprac_pkg::dsprac_word_t   peekLo
);
  import dsprac_pkg::*;

  dsprac_acc_if  accIf ();
  dsprac_state_e state;
  dsprac_op_e    decOp;
  logic          take;
  logic [5:0]    shiftAmt;
  dsprac_sel_t   accSel;
  logic          shNeg;
  logic [5:0]    shMag;
  logic [63:0]   joined;
  logic [63:0]   next_acc;
  dsprac_word_t  halfRes;
  logic [1:0]    halfOvf;
  logic          satForm;

  dsprac_acc_mem u_mem (
    .clk     (clk),
    .reset_n (reset_n),
    .acc     (accIf)
  );

  assign take = issueValid && issueReady;

  // decoder
  always_comb begin
    decOp = DSPRAC_OP_NONE;
    if (issueInstr[`DSPRAC_F_MAJOR] == `DSPRAC_MAJOR) begin
      if (issueInstr[`DSPRAC_F_MINOR10HI] == `DSPRAC_MIN_REPL_PH && issueInstr[`DSPRAC_F_POOLX] == `DSPRAC_POOLX) begin
        decOp = DSPRAC_OP_REPL_PH;
      end
      else if (issueInstr[`DSPRAC_F_MINOR10HI] == `DSPRAC_MIN_REPL_QB
               && issueInstr[`DSPRAC_F_POOLX] == `DSPRAC_POOLX) begin
        decOp = DSPRAC_OP_REPL_QB;
      end
      else if (issueInstr[`DSPRAC_F_MINOR10LO] == `DSPRAC_MIN_ACC_IMM
               && issueInstr[`DSPRAC_F_ZERO4HI] == `DSPRAC_ZERO4
               && issueInstr[`DSPRAC_F_ZERO4LO] == `DSPRAC_ZERO4) begin
        decOp = DSPRAC_OP_ACC_IMM;
      end
      else if (issueInstr[`DSPRAC_F_MINOR8] == `DSPRAC_MIN_ACC_VAR
               && issueInstr[`DSPRAC_F_POOLX] == `DSPRAC_POOLX
               && issueInstr[`DSPRAC_F_ZERO5] == `DSPRAC_ZERO5) begin
        decOp = DSPRAC_OP_ACC_VAR;
      end
      else if (issueInstr[`DSPRAC_F_MINOR12] == `DSPRAC_MIN_HSHL) begin
        decOp = DSPRAC_OP_HSHL;
      end else if (issueInstr[`DSPRAC_F_MINOR12] == `DSPRAC_MIN_HSHL_SAT) begin
        decOp = DSPRAC_OP_HSHL_SAT;
      end
    end
  end

  // per-half shift with overflow and clamp
  assign satForm = (decOp == DSPRAC_OP_HSHL_SAT);
  for (genvar h = 0; h < 2; h++) begin : g_half
    logic [15:0] a;
    logic [3:0]  s;
    logic [15:0] chk;
    assign a   = issueRsValue[h*16 +: 16];
    assign s   = issueInstr[`DSPRAC_F_HSA];
    assign chk = 16'($signed(a) >>> (`DSPRAC_HALF_MSB - s));
    assign halfOvf[h] = (s != `DSPRAC_ZERO4) && (chk != `DSPRAC_ZERO16) && (chk != `DSPRAC_ONES16);
    assign halfRes[h*16 +: 16] = (satForm && halfOvf[h]) ? (a[15] ? `DSPRAC_SAT_NEG : `DSPRAC_SAT_POS)
                                                         : 16'(a << s);
  end

  // accumulator read selection
  // selector names one of four pairs
  assign accIf.rdSel = issueInstr[`DSPRAC_F_ACSEL];
  assign accIf.pkSel = peekSel;

  // join, shift and split the pair
  // signed amount, magnitude up to 32
  assign shNeg    = shiftAmt[`DSPRAC_SIGN6];
  assign shMag    = shNeg ? 6'(-shiftAmt) : shiftAmt;
  assign joined   = {accIf.rdHi, accIf.rdLo};
  assign next_acc = shNeg ? (joined << shMag) : (joined >> shMag);

  always_comb begin
    accIf.wrEn  = 1'b0;
    accIf.wrSel = extWrSel;
    accIf.wrHi  = extWrHi;
    accIf.wrLo  = extWrLo;
    if (state == DSPRAC_EXEC) begin
      accIf.wrEn  = 1'b1;
      accIf.wrSel = accSel;
      accIf.wrHi  = next_acc[63:32];
      accIf.wrLo  = next_acc[31:0];
    end else if (extWrEn) begin
      accIf.wrEn  = 1'b1;
    end
  end

  // sequencing of accumulator ops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= DSPRAC_IDLE;
      issueReady <= 1'b0;
      shiftAmt   <= 6'h00;
      accSel     <= 2'h0;
    end else begin
      case (state)
        DSPRAC_IDLE: begin
          issueReady <= 1'b1;
          if (take && dspEnable && (decOp == DSPRAC_OP_ACC_IMM || decOp == DSPRAC_OP_ACC_VAR)) begin
            state      <= DSPRAC_EXEC;
            issueReady <= 1'b0;
            accSel     <= issueInstr[`DSPRAC_F_ACSEL];
            // variable amount from source bits 5..0
            shiftAmt   <= (decOp == DSPRAC_OP_ACC_VAR) ? issueRsValue[`DSPRAC_F_VARSHIFT]
                                                       : issueInstr[`DSPRAC_F_IMMSHIFT];
          end
        end
        DSPRAC_EXEC: begin
          state      <= DSPRAC_IDLE;
          issueReady <= 1'b1;
        end
        default: begin
          state      <= DSPRAC_IDLE;
          issueReady <= 1'b0;
        end
      endcase
    end
  end

  // register results and exceptions
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resValid    <= 1'b0;
      gprWrEn     <= 1'b0;
      gprDest     <= 5'h00;
      gprData     <= `DSPRAC_ZERO32;
      excReserved <= 1'b0;
      excDspOff   <= 1'b0;
      ouflagSet   <= 1'b0;
    end else begin
      resValid    <= take;
      gprWrEn     <= 1'b0;
      excReserved <= 1'b0;
      excDspOff   <= 1'b0;
      ouflagSet   <= 1'b0;
      if (take) begin
        gprDest <= issueInstr[`DSPRAC_F_DEST];
        // only reserved or disabled, never data dependent
        if (decOp == DSPRAC_OP_NONE) begin
          excReserved <= 1'b1;
        end else if (!dspEnable) begin
          excDspOff <= 1'b1;
        end else begin
          case (decOp)
            DSPRAC_OP_REPL_PH: begin
              gprWrEn <= 1'b1;
              gprData <= {2{issueRsValue[`DSPRAC_F_HALF0]}};
            end
            DSPRAC_OP_REPL_QB: begin
              gprWrEn <= 1'b1;
              gprData <= {4{issueRsValue[`DSPRAC_F_BYTE0]}};
            end
            DSPRAC_OP_HSHL, DSPRAC_OP_HSHL_SAT: begin
              gprWrEn   <= 1'b1;
              gprData   <= halfRes;
              ouflagSet <= |halfOvf;
            end
            default: begin
              gprWrEn <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // accumulator completion
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      accDone <= 1'b0;
    end else begin
      accDone <= (state == DSPRAC_EXEC);
    end
  end

  assign peekHi = accIf.pkHi;
  assign peekLo = accIf.pkLo;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  repl_half_a: assert property (
    take && dspEnable && decOp == DSPRAC_OP_REPL_PH
    |=> gprWrEn && gprData == {2{$past(issueRsValue[15:0])}})
    else $error("halfword replicate result wrong");

  repl_byte_a: assert property (
    take && dspEnable && decOp == DSPRAC_OP_REPL_QB
    |=> gprWrEn && gprData == {4{$past(issueRsValue[7:0])}})
    else $error("byte replicate result wrong");

  acc_seq_a: assert property (
    take && dspEnable && decOp == DSPRAC_OP_ACC_IMM
    |=> state == DSPRAC_EXEC && accIf.wrEn && !issueReady ##1 accDone && issueReady)
    else $error("accumulator op sequence wrong");

  acc_sel_a: assert property (
    take && dspEnable && decOp == DSPRAC_OP_ACC_VAR
    |=> accIf.wrSel == $past(issueInstr[15:14]) && shiftAmt == $past(issueRsValue[5:0]))
    else $error("accumulator selector or variable amount wrong");

  zero_shift_a: assert property (
    state == DSPRAC_EXEC && shiftAmt == 6'h00
    |-> accIf.wrHi == accIf.rdHi && accIf.wrLo == accIf.rdLo)
    else $error("zero shift changed accumulator");

  right_fill_a: assert property (
    state == DSPRAC_EXEC && !shiftAmt[5] && shiftAmt != 6'h00
    |-> !accIf.wrHi[31] && accIf.wrLo == 32'(joined >> shiftAmt))
    else $error("right shift not zero filled");

  left_max_a: assert property (
    state == DSPRAC_EXEC && shiftAmt == 6'h20
    |-> accIf.wrLo == 32'h0000_0000 && accIf.wrHi == accIf.rdLo)
    else $error("left shift by 32 wrong");

  exc_nowrite_a: assert property (
    excReserved || excDspOff |-> !gprWrEn && !ouflagSet && !accDone && resValid)
    else $error("exception with side effect");

  sat_clamp_a: assert property (
    take && dspEnable && satForm && halfOvf[1]
    |=> ouflagSet && (gprData[31:16] == 16'h7FFF || gprData[31:16] == 16'h8000))
    else $error("saturation clamp missing");

  zero_half_a: assert property (
    take && dspEnable && decOp == DSPRAC_OP_HSHL && issueInstr[15:12] == 4'h0
    |=> gprData == $past(issueRsValue) && !ouflagSet)
    else $error("zero halfword shift changed data");

  one_write_a: assert property (
    state == DSPRAC_EXEC |-> accIf.wrEn && accIf.wrSel == accSel)
    else $error("accumulator writeback split");

  cov_repl_c: cover property (take && dspEnable && decOp == DSPRAC_OP_REPL_QB);
  cov_left_c: cover property (state == DSPRAC_EXEC && shiftAmt[5]);
  cov_sat_c: cover property (take && dspEnable && satForm && |halfOvf);
  cov_res_c: cover property (take && decOp == DSPRAC_OP_NONE);
endmodule
`default_nettype wire

/* File: inc/dsprac_regs.svh */
// Purpose: encodings, field positions and constants of the replicate and accumulator-shift datapath
// Assumes: 32-bit instruction words, four 64-bit accumulator pairs
// Notes:   definitions only
`ifndef DSPRAC_REGS_SVH
`define DSPRAC_REGS_SVH

// instruction fields
`define DSPRAC_F_MAJOR      31:26
`define DSPRAC_F_DEST       25:21
`define DSPRAC_F_ZERO5      25:21
`define DSPRAC_F_ZERO4HI    25:22
`define DSPRAC_F_IMMSHIFT   21:16
`define DSPRAC_F_ACSEL      15:14
`define DSPRAC_F_ZERO4LO    13:10
`define DSPRAC_F_MINOR10HI  15:6
`define DSPRAC_F_MINOR10LO  9:0
`define DSPRAC_F_MINOR8     13:6
`define DSPRAC_F_POOLX      5:0
`define DSPRAC_F_HSA        15:12
`define DSPRAC_F_MINOR12    11:0
`define DSPRAC_F_VARSHIFT   5:0
`define DSPRAC_F_BYTE0      7:0
`define DSPRAC_F_HALF0      15:0
`define DSPRAC_SIGN6        5

// opcode values
`define DSPRAC_MAJOR        6'h00
`define DSPRAC_POOLX        6'h3C
`define DSPRAC_MIN_REPL_PH  10'h00C
`define DSPRAC_MIN_REPL_QB  10'h04C
`define DSPRAC_MIN_ACC_IMM  10'h01D
`define DSPRAC_MIN_ACC_VAR  8'h49
`define DSPRAC_MIN_HSHL     12'h3B5
`define DSPRAC_MIN_HSHL_SAT 12'hBB5

// constants
`define DSPRAC_ZERO4        4'h0
`define DSPRAC_ZERO5        5'h00
`define DSPRAC_HALF_MSB     4'hF
`define DSPRAC_ONES16       16'hFFFF
`define DSPRAC_ZERO16       16'h0000
`define DSPRAC_SAT_POS      16'h7FFF
`define DSPRAC_SAT_NEG      16'h8000
`define DSPRAC_ZERO32       32'h0000_0000
`define DSPRAC_ACC_COUNT    4

`endif

/* File: inc/dsprac_pkg.sv */
// Purpose: types of the replicate and accumulator-shift datapath
// Assumes: nothing
// Notes:   constants live in dsprac_regs.svh
package dsprac_pkg;
  typedef enum logic [0:0] {
    DSPRAC_IDLE = 1'b0,
    DSPRAC_EXEC = 1'b1
  } dsprac_state_e;

  typedef enum logic [2:0] {
    DSPRAC_OP_NONE      = 3'b000,
    DSPRAC_OP_REPL_PH   = 3'b001,
    DSPRAC_OP_REPL_QB   = 3'b010,
    DSPRAC_OP_ACC_IMM   = 3'b011,
    DSPRAC_OP_ACC_VAR   = 3'b100,
    DSPRAC_OP_HSHL      = 3'b101,
    DSPRAC_OP_HSHL_SAT  = 3'b110
  } dsprac_op_e;

  typedef logic [1:0]  dsprac_sel_t;
  typedef logic [31:0] dsprac_word_t;
endpackage

/* File: inc/dsprac_acc_if.sv */
// Purpose: accumulator storage access between datapath and accumulator memory
// Assumes: one clock
// Notes:   read data registered inside the memory
`timescale 1ns/10ps
`default_nettype none
interface dsprac_acc_if;
  import dsprac_pkg::*;
  dsprac_sel_t  rdSel;
  dsprac_word_t rdHi;
  dsprac_word_t rdLo;
  logic         wrEn;
  dsprac_sel_t  wrSel;
  dsprac_word_t wrHi;
  dsprac_word_t wrLo;
  dsprac_sel_t  pkSel;
  dsprac_word_t pkHi;
  dsprac_word_t pkLo;

  modport mem (input rdSel, wrEn, wrSel, wrHi, wrLo, pkSel, output rdHi, rdLo, pkHi, pkLo);
  modport user (output rdSel, wrEn, wrSel, wrHi, wrLo, pkSel, input rdHi, rdLo, pkHi, pkLo);
endinterface
`default_nettype wire

/* File: rtl/dsprac_acc_mem.sv */
// Purpose: four 64-bit accumulator pairs, one write port, two registered read ports
// Assumes: upper and lower words always written together
// Notes:   exec read port forwards a same-cycle write
`timescale 1ns/10ps
`default_nettype none
`include "dsprac_regs.svh"
module dsprac_acc_mem (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // accumulator access
  dsprac_acc_if.mem acc
);
  import dsprac_pkg::*;

  dsprac_word_t hiMem [`DSPRAC_ACC_COUNT];
  dsprac_word_t loMem [`DSPRAC_ACC_COUNT];

  // one entry per accumulator, both halves in one write
  for (genvar i = 0; i < `DSPRAC_ACC_COUNT; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (acc.wrEn && acc.wrSel == dsprac_sel_t'(i)) begin
        hiMem[i] <= acc.wrHi;
        loMem[i] <= acc.wrLo;
      end
    end
  end

  // exec read with write forwarding
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc.rdHi <= `DSPRAC_ZERO32;
      acc.rdLo <= `DSPRAC_ZERO32;
    end else if (acc.wrEn && acc.wrSel == acc.rdSel) begin
      acc.rdHi <= acc.wrHi;
      acc.rdLo <= acc.wrLo;
    end else begin
      acc.rdHi <= hiMem[acc.rdSel];
      acc.rdLo <= loMem[acc.rdSel];
    end
  end

  // observation read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc.pkHi <= `DSPRAC_ZERO32;
      acc.pkLo <= `DSPRAC_ZERO32;
    end else begin
      acc.pkHi <= hiMem[acc.pkSel];
      acc.pkLo <= loMem[acc.pkSel];
    end
  end
endmodule
`default_nettype wire

/* File: bench/dsprac_pipe_model.sv */
// Purpose: pipeline writeback side, register file and overflow flag
// Assumes: results arrive as one-cycle pulses
// Notes:   flag bit stays set until reset
`timescale 1ns/10ps
`default_nettype none
module dsprac_pipe_model (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // result
  input  wire logic                    resValid,
  input  wire logic                    gprWrEn,
  input  wire logic [4:0]              gprDest,
  input  wire dsprac_pkg::dsprac_word_t gprData,
  input  wire logic                    ouflagSet
);
  import dsprac_pkg::*;
  dsprac_word_t gpr [32];
  dsprac_word_t dspCtrl;

  always_ff @(posedge clk) begin
    if (resValid && gprWrEn) begin
      gpr[gprDest] <= gprData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dspCtrl <= 32'h0000_0000;
    end else if (ouflagSet) begin
      dspCtrl[22] <= 1'h1;
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Purpose: self-checking bench of the replicate and accumulator-shift datapath
// Assumes: pipeline model takes back results
// Notes:   accumulators loaded through the external write port
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dsprac_pkg::*;
  logic         clk, reset_n, issueValid, dspEnable, extWrEn;
  logic         issueReady, resValid, gprWrEn, excReserved, excDspOff, ouflagSet, accDone;
  logic [4:0]   gprDest;
  dsprac_word_t issueInstr, issueRsValue, extWrHi, extWrLo, gprData, peekHi, peekLo;
  dsprac_sel_t  extWrSel, peekSel;
  int           n_fail = 0;
  int           n_tests = 0;
  int           cyc = 0;
  logic [63:0]  accInit = 64'hF00D_0001_8000_0003;

  dsprac_top u_dut (.clk(clk), .reset_n(reset_n), .issueValid(issueValid), .issueInstr(issueInstr),
    .issueRsValue(issueRsValue), .dspEnable(dspEnable), .issueReady(issueReady), .resValid(resValid),
    .gprWrEn(gprWrEn), .gprDest(gprDest), .gprData(gprData), .excReserved(excReserved),
    .excDspOff(excDspOff), .ouflagSet(ouflagSet), .accDone(accDone), .extWrEn(extWrEn),
    .extWrSel(extWrSel), .extWrHi(extWrHi), .extWrLo(extWrLo), .peekSel(peekSel),
    .peekHi(peekHi), .peekLo(peekLo));
  dsprac_pipe_model u_pipe (.clk(clk), .reset_n(reset_n), .resValid(resValid), .gprWrEn(gprWrEn),
    .gprDest(gprDest), .gprData(gprData), .ouflagSet(ouflagSet));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task end_sim;
    $display("compares %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      $display("unexpected %0t timeout", $time);
      end_sim();
    end
  end

  task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask

  function automatic logic [63:0] sh(input logic [63:0] v, input logic [5:0] a);
    return a[5] ? v << (7'h40 - {1'h0, a}) : v >> a;
  endfunction

  function automatic dsprac_word_t hs(input logic [4:0] rt, input logic [3:0] sa, input logic [11:0] mn);
    return {6'h00, rt, 5'h00, sa, mn};
  endfunction

  task issue(input dsprac_word_t i, input dsprac_word_t r);
    @(posedge clk);
    issueValid   <= 1'h1;
    issueInstr   <= i;
    issueRsValue <= r;
    do @(posedge clk); while (issueReady !== 1'h1);
    issueValid <= 1'h0;
    #1;
  endtask

  task reg_op(input dsprac_word_t i, input dsprac_word_t r, input dsprac_word_t exp, input logic flag);
    issue(i, r);
    chk({resValid, gprWrEn, ouflagSet, excReserved, excDspOff}, {2'h3, flag, 2'h0}, "result flags");
    chk(gprData, exp, "result data");
    chk(gprDest, i[25:21], "destination");
    @(posedge clk);
    #1;
    chk(u_pipe.gpr[i[25:21]], exp, "register file");
  endtask

  task load(input dsprac_sel_t s, input logic [63:0] v);
    @(posedge clk);
    extWrEn            <= 1'h1;
    extWrSel           <= s;
    {extWrHi, extWrLo} <= v;
    peekSel            <= s;
    @(posedge clk);
    extWrEn <= 1'h0;
  endtask

  task acc_op(input dsprac_word_t i, input dsprac_word_t r, input dsprac_sel_t s, input logic [63:0] exp);
    load(s, accInit);
    issue(i, r);
    chk({resValid, gprWrEn, issueReady}, 3'h4, "acc issue");
    @(posedge clk);
    #1;
    chk(accDone, 1'h1, "acc done");
    @(posedge clk);
    #1;
    chk({peekHi, peekLo}, exp, "acc value");
  endtask

  task t_repl;
    reg_op({6'h00, 5'h03, 5'h07, 10'h00C, 6'h3C}, 32'hDEAD_BEEF, 32'hBEEF_BEEF, 1'h0);
    reg_op({6'h00, 5'h1F, 5'h07, 10'h04C, 6'h3C}, 32'h1234_56A5, 32'hA5A5_A5A5, 1'h0);
  endtask

  task t_acc_imm;
    logic [5:0] amt [4];
    amt = '{6'h1F, 6'h20, 6'h00, 6'h3F};
    for (int k = 0; k < 4; k++) begin
      acc_op({6'h00, 4'h0, amt[k], 2'(k), 4'h0, 10'h01D}, 32'h0, 2'(k), sh(accInit, amt[k]));
    end
    @(posedge clk);
    peekSel <= 2'h0;
    repeat (2) @(posedge clk);
    #1;
    chk({peekHi, peekLo}, sh(accInit, 6'h1F), "pair zero kept");
  endtask

  task t_acc_var;
    acc_op({6'h00, 5'h00, 5'h04, 2'h2, 8'h49, 6'h3C}, 32'hFFFF_FFC4, 2'h2, sh(accInit, 6'h04));
    acc_op({6'h00, 5'h00, 5'h04, 2'h3, 8'h49, 6'h3C}, 32'h0000_0FF8, 2'h3, sh(accInit, 6'h38));
  endtask

  task t_half;
    reg_op(hs(5'h05, 4'h1, 12'h3B5), 32'hC001_0003, 32'h8002_0006, 1'h0);
    reg_op(hs(5'h08, 4'h0, 12'h3B5), 32'h8001_7FFF, 32'h8001_7FFF, 1'h0);
    chk(u_pipe.dspCtrl[22], 1'h0, "flag clear");
    reg_op(hs(5'h06, 4'h2, 12'h3B5), 32'h4001_0003, 32'h0004_000C, 1'h1);
    reg_op(hs(5'h07, 4'h1, 12'hBB5), 32'h8000_7000, 32'h8000_7FFF, 1'h1);
    chk(u_pipe.dspCtrl[22], 1'h1, "flag set");
  endtask

  task t_exc;
    @(posedge clk);
    dspEnable <= 1'h0;
    issue({6'h00, 5'h03, 5'h07, 10'h04C, 6'h3C}, 32'h0000_0011);
    chk({excDspOff, excReserved, gprWrEn, ouflagSet}, 4'h8, "disabled op");
    load(2'h1, accInit);
    issue({6'h00, 4'h0, 6'h01, 2'h1, 4'h0, 10'h01D}, 32'h0);
    chk({excDspOff, gprWrEn}, 2'h2, "disabled acc");
    repeat (2) @(posedge clk);
    #1;
    chk({peekHi, peekLo}, accInit, "acc untouched");
    issue(32'hFFFF_FFFF, 32'h0);
    chk({excReserved, excDspOff, gprWrEn}, 3'h4, "reserved disabled");
    @(posedge clk);
    dspEnable <= 1'h1;
    issue({6'h00, 5'h03, 5'h07, 10'h0FF, 6'h3C}, 32'h0);
    chk({excReserved, excDspOff, gprWrEn}, 3'h4, "reserved");
  endtask

  initial begin
    reset_n      = 1'h0;
    issueValid   = 1'h0;
    issueInstr   = 32'h0;
    issueRsValue = 32'h0;
    dspEnable    = 1'h1;
    extWrEn      = 1'h0;
    extWrSel     = 2'h0;
    extWrHi      = 32'h0;
    extWrLo      = 32'h0;
    peekSel      = 2'h0;
    @(posedge clk);
    #1;
    chk({issueReady, resValid, accDone}, 3'h0, "reset outputs");
    @(posedge clk);
    reset_n <= 1'h1;
    t_repl();
    t_acc_imm();
    t_acc_var();
    t_half();
    t_exc();
    end_sim();
  end
endmodule
`default_nettype wire
